// ===== hdl/chip_reset_control.sv
`timescale 1ns/1ps
module chip_reset_control
	import chip_reset_pkg::*;
#(
	parameter int PorReleaseCyc = POR_RELEASE_CYC,
	parameter int RxReleaseCyc  = RX_RELEASE_CYC,
	parameter int SwReleaseCyc  = SW_RELEASE_CYC,
	parameter int RamCheckCyc   = RAM_CHECK_CYC,
	parameter int RxLowMinCyc   = RX_LOW_MIN_CYC
)
(
	input  wire logic        clk,       // 40 MHz chip clock
	input  wire logic        sys_rst,   // Synchronous reset, high
	input  wire logic        supplyOk,  // Supply monitor: high above 1.45 V, async
	input  wire logic        rxPin,     // Serial receive line, async
	input  wire logic        ramFault,  // RAM check error strobe, same clock
	input  wire apbReq_t     apbIn,     // APB request
	output logic             pready,    // APB ready
	output logic [31:0]      prdata,    // APB read data
	output logic             pslverr,   // APB error on unmapped index
	output logic             chipRst,   // Chip held in reset
	output logic             uartEn,    // Serial interface may run
	output logic             ramAccess, // RAM open to host and datapath
	output logic             irq        // Level interrupt
);

	// Two-flop synchronisers for the pins
	logic supplySync1_r;
	logic supplySync_r;
	logic rxSync1_r;
	logic rxSync_r;

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			supplySync1_r <= 1'b0;
			supplySync_r  <= 1'b0;
			rxSync1_r     <= 1'b1;
			rxSync_r      <= 1'b1;
		end
		else
		begin
			supplySync1_r <= supplyOk;
			supplySync_r  <= supplySync1_r;
			rxSync1_r     <= rxPin;
			rxSync_r      <= rxSync1_r;
		end
	end

	// APB decode
	logic [IDX_W-1:0] idx;
	logic             setupPh;
	logic             wrEn;
	logic             mapped;
	logic             keyWrite;

	assign idx      = apbIn.paddr[ADDR_W-1:2];
	assign setupPh  = apbIn.psel && !apbIn.penable;
	assign wrEn     = apbIn.psel && apbIn.penable && pready && apbIn.pwrite;
	assign mapped   = (idx == IDX_SYS_CTRL) || (idx == IDX_SW_RESET) ||
	                  (idx == IDX_IRQ_STATUS) || (idx == IDX_IRQ_MASK);
	assign keyWrite = wrEn && (idx == IDX_SW_RESET) && (apbIn.pwdata == SW_RESET_KEY);

	// Reset sequencer state
	rstState_t        state_r, state_nxt;
	logic [CNT_W-1:0] cnt_r, cnt_nxt;
	logic [CNT_W-1:0] rxLowCnt_r, rxLowCnt_nxt;
	logic [2:0]       source_r, source_nxt;
	logic             rxTrip;
	logic             exitNow;

	assign rxTrip  = !rxSync_r && (rxLowCnt_r == CNT_W'(RxLowMinCyc - 1));
	assign exitNow = (state_r == sRelease) && (cnt_r == '0);

	// Next state: supply loss beats line reset, which beats the key
	always_comb
	begin
		state_nxt    = state_r;
		cnt_nxt      = cnt_r;
		source_nxt   = source_r;
		rxLowCnt_nxt = rxLowCnt_r;
		if (rxSync_r || state_r == sPorHold || state_r == sRxHold)
			rxLowCnt_nxt = '0;
		else if (!rxTrip)
			rxLowCnt_nxt = rxLowCnt_r + 1'b1;
		if (!supplySync_r)
		begin
			state_nxt  = sPorHold;
			source_nxt = SRC_POR;
		end
		else if (rxTrip && state_r != sPorHold)
		begin
			state_nxt  = sRxHold;
			source_nxt = SRC_RX;
		end
		else
		begin
			case (state_r)
				sPorHold:
				begin
					state_nxt = sRelease;
					cnt_nxt   = CNT_W'(PorReleaseCyc - 1);
				end
				sRxHold:
				begin
					if (rxSync_r)
					begin
						state_nxt = sRelease;
						cnt_nxt   = CNT_W'(RxReleaseCyc - 1);
					end
				end
				sRelease:
				begin
					if (cnt_r == '0)
						state_nxt = sRun;
					else
						cnt_nxt = cnt_r - 1'b1;
				end
				default:
				begin
					// Key acts only while running; during reset it is just stored
					if (keyWrite)
					begin
						state_nxt  = sRelease;
						cnt_nxt    = CNT_W'(SwReleaseCyc - 1);
						source_nxt = SRC_SW;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			state_r    <= sPorHold;
			cnt_r      <= '0;
			rxLowCnt_r <= '0;
			source_r   <= SRC_POR;
		end
		else
		begin
			state_r    <= state_nxt;
			cnt_r      <= cnt_nxt;
			rxLowCnt_r <= rxLowCnt_nxt;
			source_r   <= source_nxt;
		end
	end

	// RAM self-check after exit; a fault anywhere in the window keeps RAM shut
	logic [CNT_W-1:0] ramCnt_r, ramCnt_nxt;
	logic             ramBusy_r, ramBusy_nxt;
	logic             ramErr_r, ramErr_nxt;
	logic             ramOk_r, ramOk_nxt;
	logic             ramDone;
	logic             inResetNxt;

	assign inResetNxt = (state_nxt != sRun);
	assign ramDone    = ramBusy_r && (ramCnt_r == '0);

	always_comb
	begin
		ramCnt_nxt  = ramCnt_r;
		ramBusy_nxt = ramBusy_r;
		ramErr_nxt  = ramErr_r;
		ramOk_nxt   = ramOk_r;
		if (inResetNxt)
		begin
			ramBusy_nxt = 1'b0;
			ramOk_nxt   = 1'b0;
		end
		else if (exitNow)
		begin
			ramBusy_nxt = 1'b1;
			ramErr_nxt  = 1'b0;
			ramCnt_nxt  = CNT_W'(RamCheckCyc - 1);
		end
		else if (ramBusy_r)
		begin
			ramErr_nxt = ramErr_r || ramFault;
			if (ramDone)
			begin
				ramBusy_nxt = 1'b0;
				ramOk_nxt   = !(ramErr_r || ramFault);
			end
			else
				ramCnt_nxt = ramCnt_r - 1'b1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			ramCnt_r  <= '0;
			ramBusy_r <= 1'b0;
			ramErr_r  <= 1'b0;
			ramOk_r   <= 1'b0;
		end
		else
		begin
			ramCnt_r  <= ramCnt_nxt;
			ramBusy_r <= ramBusy_nxt;
			ramErr_r  <= ramErr_nxt;
			ramOk_r   <= ramOk_nxt;
		end
	end

	// Register file; control bits fall to default while the chip is in reset
	logic [SYS_RW_W-1:0] system_control_r, system_control_nxt;
	logic [31:0]         swKey_r, swKey_nxt;
	logic [IRQ_W-1:0]    irqStat_r, irqStat_nxt;
	logic [IRQ_W-1:0]    irqMask_r, irqMask_nxt;
	logic [IRQ_W-1:0]    irqSet;
	logic [31:0]         readMux;

	assign irqSet = {ramDone && (ramErr_r || ramFault), ramDone && !(ramErr_r || ramFault), exitNow};

	always_comb
	begin
		system_control_nxt = system_control_r;
		swKey_nxt   = swKey_r;
		irqMask_nxt = irqMask_r;
		irqStat_nxt = irqStat_r;
		if (wrEn && idx == IDX_SYS_CTRL)
			system_control_nxt = apbIn.pwdata[SYS_RW_W-1:0];
		if (wrEn && idx == IDX_SW_RESET)
			swKey_nxt = apbIn.pwdata;
		if (wrEn && idx == IDX_IRQ_MASK)
			irqMask_nxt = apbIn.pwdata[IRQ_W-1:0];
		if (wrEn && idx == IDX_IRQ_STATUS)
			irqStat_nxt = irqStat_r & ~apbIn.pwdata[IRQ_W-1:0];
		// Set after clear so an event in the clearing cycle survives
		irqStat_nxt = irqStat_nxt | irqSet;
		if (state_r != sRun)
		begin
			system_control_nxt = '0;
			if (!(wrEn && idx == IDX_SW_RESET))
				swKey_nxt = '0;
		end
	end

	// Read mux; reserved bits of system control read zero
	always_comb
	begin
		readMux = ZERO_WORD;
		if (idx == IDX_SYS_CTRL)
		begin
			readMux[SYS_RW_W-1:0]      = system_control_r;
			readMux[SRC_MSB:SRC_LSB]   = source_r;
		end
		else if (idx == IDX_SW_RESET)
			readMux = swKey_r;
		else if (idx == IDX_IRQ_STATUS)
			readMux[IRQ_W-1:0] = irqStat_r;
		else if (idx == IDX_IRQ_MASK)
			readMux[IRQ_W-1:0] = irqMask_r;
	end

	// Registers and flopped outputs; ready rises in every access phase
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			system_control_r <= '0;
			swKey_r   <= '0;
			irqStat_r <= '0;
			irqMask_r <= '0;
			pready    <= 1'b0;
			prdata    <= ZERO_WORD;
			pslverr   <= 1'b0;
			chipRst   <= 1'b1;
			uartEn    <= 1'b0;
			ramAccess <= 1'b0;
			irq       <= 1'b0;
		end
		else
		begin
			system_control_r <= system_control_nxt;
			swKey_r   <= swKey_nxt;
			irqStat_r <= irqStat_nxt;
			irqMask_r <= irqMask_nxt;
			pready    <= setupPh;
			prdata    <= (setupPh && !apbIn.pwrite) ? readMux : ZERO_WORD;
			pslverr   <= setupPh && !mapped;
			chipRst   <= inResetNxt;
			uartEn    <= !inResetNxt;
			ramAccess <= ramOk_nxt;
			irq       <= |(irqStat_nxt & irqMask_nxt);
		end
	end

	// Checks on the sequencer
	property p_supplyHold;
		@(posedge clk) disable iff (sys_rst) !supplySync_r |=> chipRst && state_r == sPorHold;
	endproperty
	a_supplyHold: assert property (p_supplyHold) else $error("reset not held on low supply");
	property p_porSource;
		@(posedge clk) disable iff (sys_rst) state_r == sPorHold |-> source_r == SRC_POR;
	endproperty
	a_porSource: assert property (p_porSource) else $error("power-on source code wrong");
	property p_porRelease;
		@(posedge clk) disable iff (sys_rst)
			(state_r == sPorHold && supplySync_r) |=> state_r == sRelease && cnt_r == CNT_W'(PorReleaseCyc - 1);
	endproperty
	a_porRelease: assert property (p_porRelease) else $error("power-on release delay wrong");
	property p_ramShut;
		@(posedge clk) disable iff (sys_rst) chipRst |-> !ramAccess && !uartEn;
	endproperty
	a_ramShut: assert property (p_ramShut) else $error("RAM or serial active in reset");
	property p_uartStart;
		@(posedge clk) disable iff (sys_rst) $fell(chipRst) |-> uartEn && !ramAccess [*8];
	endproperty
	a_uartStart: assert property (p_uartStart) else $error("serial late or RAM open early");
	property p_ramCheckLoad;
		@(posedge clk) disable iff (sys_rst) exitNow |=> ramBusy_r && ramCnt_r == CNT_W'(RamCheckCyc - 1);
	endproperty
	a_ramCheckLoad: assert property (p_ramCheckLoad) else $error("RAM check not started on exit");
	// Power-on hold outranks a count that ran up during the supply loss
	property p_rxTrip;
		@(posedge clk) disable iff (sys_rst)
			(rxTrip && supplySync_r && state_r != sPorHold) |=> state_r == sRxHold && source_r == SRC_RX;
	endproperty
	a_rxTrip: assert property (p_rxTrip) else $error("line reset not taken");
	property p_rxRelease;
		@(posedge clk) disable iff (sys_rst)
			(state_r == sRxHold && rxSync_r && supplySync_r && !rxTrip) |=>
			state_r == sRelease && cnt_r == CNT_W'(RxReleaseCyc - 1);
	endproperty
	a_rxRelease: assert property (p_rxRelease) else $error("line release delay wrong");
	property p_noReserved;
		@(posedge clk) disable iff (sys_rst) source_r != 3'h0 && source_r != 3'h2;
	endproperty
	a_noReserved: assert property (p_noReserved) else $error("reserved source code reported");
	property p_keyReset;
		@(posedge clk) disable iff (sys_rst)
			(keyWrite && state_r == sRun && supplySync_r && !rxTrip) |=>
			chipRst && source_r == SRC_SW && cnt_r == CNT_W'(SwReleaseCyc - 1);
	endproperty
	a_keyReset: assert property (p_keyReset) else $error("software reset not taken");
	property p_otherValue;
		@(posedge clk) disable iff (sys_rst)
			(wrEn && idx == IDX_SW_RESET && !keyWrite && state_r == sRun && supplySync_r && !rxTrip) |=>
			!chipRst && swKey_r == $past(apbIn.pwdata);
	endproperty
	a_otherValue: assert property (p_otherValue) else $error("plain write misbehaved");
	property p_defaultState;
		@(posedge clk) disable iff (sys_rst) $rose(chipRst) |=> system_control_r == '0;
	endproperty
	a_defaultState: assert property (p_defaultState) else $error("control not defaulted");

endmodule

// ===== common/chip_reset_pkg.sv
package chip_reset_pkg;
	// Clock and documented timing, times in nanoseconds
	localparam int CLK_PERIOD_NS   = 25;
	localparam int POR_RELEASE_NS  = 500000;
	localparam int RX_RELEASE_NS   = 900000;
	localparam int SW_RELEASE_NS   = 650000;
	localparam int RAM_CHECK_NS    = 1250000;
	localparam int RX_LOW_MIN_NS   = 64000000;
	// Cycle counts: longest times round down, least times round up
	localparam int POR_RELEASE_CYC = POR_RELEASE_NS / CLK_PERIOD_NS;
	localparam int RX_RELEASE_CYC  = RX_RELEASE_NS / CLK_PERIOD_NS;
	localparam int SW_RELEASE_CYC  = SW_RELEASE_NS / CLK_PERIOD_NS;
	localparam int RAM_CHECK_CYC   = RAM_CHECK_NS / CLK_PERIOD_NS;
	localparam int RX_LOW_MIN_CYC  = (RX_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W           = 22;

	// Register indexes; byte address is four times the index
	localparam int          ADDR_W         = 12;
	localparam int          IDX_W          = 10;
	localparam logic [9:0]  IDX_SYS_CTRL   = 10'h180;
	localparam logic [9:0]  IDX_SW_RESET   = 10'h1BF;
	localparam logic [9:0]  IDX_IRQ_STATUS = 10'h1C0;
	localparam logic [9:0]  IDX_IRQ_MASK   = 10'h1C1;

	// System control layout
	localparam int          SRC_LSB        = 24;
	localparam int          SRC_MSB        = 26;
	localparam int          SYS_RW_W       = 24;
	localparam logic [2:0]  SRC_POR        = 3'h1;
	localparam logic [2:0]  SRC_RX         = 3'h3;
	localparam logic [2:0]  SRC_SW         = 3'h4;
	localparam logic [31:0] SW_RESET_KEY   = 32'h4572BEAF;
	localparam logic [31:0] ZERO_WORD      = 32'h0000_0000;

	// Interrupt status and mask bits
	localparam int          IRQ_W          = 3;
	localparam int          IRQ_EXIT       = 0;
	localparam int          IRQ_RAM_OK     = 1;
	localparam int          IRQ_RAM_ERR    = 2;

	typedef enum logic [1:0] {sPorHold, sRxHold, sRelease, sRun} rstState_t;

	// APB request from the master
	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0]       pwdata;
	} apbReq_t;
endpackage

// ===== test/host_line_model.sv
`timescale 1ns/1ps
module host_line_model
(
	input  wire logic clk,   // Chip clock
	output logic      rxPin  // Receive line toward the chip
);
	// Idle line sits high between holds, so the chip never sees a stray low
	initial rxPin = 1'b1;

	// Host pulls the line low for a number of cycles, then returns it high
	task automatic holdLow(input int cyc);
		rxPin <= 1'b0;
		repeat (cyc) @(posedge clk);
		rxPin <= 1'b1;
	endtask
endmodule

// ===== test/chip_reset_control_test.sv
`timescale 1ns/1ps
module chip_reset_control_test
	import chip_reset_pkg::*;
();
	// Short counts keep the run brief; every expectation derives from them
	localparam int POR = 20, RXR = 30, SWR = 25, RAMC = 40, RXLOW = 50;
	localparam logic [11:0] A_SYS  = {IDX_SYS_CTRL, 2'h0};
	localparam logic [11:0] A_KEY  = {IDX_SW_RESET, 2'h0};
	localparam logic [11:0] A_STAT = {IDX_IRQ_STATUS, 2'h0};
	localparam logic [11:0] A_MASK = {IDX_IRQ_MASK, 2'h0};
	logic        clk, sys_rst, supplyOk, ramFault, rxPin, pready, pslverr, err;
	logic        chipRst, uartEn, ramAccess, irq;
	logic [31:0] prdata, rd, wv;
	apbReq_t     apbReq;
	int          miscompares, checks, n, seed;
	int          expSrc, expStat; // Reference model of source field and irq status

	// Free-running chip clock
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	chip_reset_control #(.PorReleaseCyc(POR), .RxReleaseCyc(RXR), .SwReleaseCyc(SWR),
		.RamCheckCyc(RAMC), .RxLowMinCyc(RXLOW)) u_chip_reset_control (.clk(clk), .sys_rst(sys_rst),
		.supplyOk(supplyOk), .rxPin(rxPin), .ramFault(ramFault), .apbIn(apbReq), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .chipRst(chipRst), .uartEn(uartEn), .ramAccess(ramAccess),
		.irq(irq));

	host_line_model u_host_line_model (.clk(clk), .rxPin(rxPin));

	task automatic compare(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("ERROR at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	// One APB transfer; an idle edge follows so the next setup is a fresh assignment
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int k;
		apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
		@(posedge clk);
		apbReq.penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge clk);
			k++;
		end
		while (pready !== 1'b1 && k < 50);
		if (k >= 50)
			miscompares++;
		rd = prdata;
		err = pslverr;
		apbReq <= '0;
		@(posedge clk);
	endtask

	task automatic rdCmp(input logic [11:0] a, input logic [31:0] exp, input string what);
		apb(1'b0, a, 32'h0);
		compare(rd, exp, what);
	endtask

	// Bounded wait for the reset output to reach a level; n holds the cycles spent
	task automatic waitRst(input logic lvl);
		n = 0;
		while (chipRst !== lvl && n < 500)
		begin
			@(posedge clk);
			n++;
		end
	endtask

	// Checks shared by every reset: idle in reset, timed exit, RAM check, reported source
	task automatic exitSeq(input int lo, input int hi, input logic [2:0] src, input logic fault);
		compare(uartEn, 1'b0, "serial idle in reset");
		compare(ramAccess, 1'b0, "ram closed in reset");
		waitRst(1'b0);
		compare(n >= lo && n <= hi, 1'b1, "release time");
		compare(uartEn, 1'b1, "serial runs at exit");
		compare(ramAccess, 1'b0, "ram closed during check");
		ramFault <= fault;
		@(posedge clk);
		ramFault <= 1'b0;
		repeat (RAMC + 4) @(posedge clk);
		compare(ramAccess, !fault, "ram after check");
		expStat |= fault ? 5 : 3;
		expSrc = src;
		rdCmp(A_SYS, {5'h0, expSrc[2:0], 24'h0}, "system control");
		rdCmp(A_KEY, 32'h0, "key cleared");
		rdCmp(A_STAT, expStat, "irq status");
	endtask

	task automatic give_verdict;
		$display("Counts: %0d checks, %0d miscompares", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Watchdog sized well above the several hundred cycles the tests need
	initial
	begin
		repeat (6000) @(posedge clk);
		miscompares++;
		give_verdict;
	end

	// Main sequence
	initial
	begin
		seed = 32'h4888515F;
		miscompares = 0;
		checks = 0;
		expStat = 0;
		sys_rst = 1'b1;
		supplyOk = 1'b0;
		ramFault = 1'b0;
		apbReq = '0;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (5) @(posedge clk);
		compare(chipRst, 1'b1, "held while supply low");
		supplyOk <= 1'b1;
		exitSeq(POR, POR + 5, SRC_POR, 1'b0);
		$display("Test power-on done");

		// Registers: random data, a non-key value, an unmapped place, interrupt path
		wv = $random(seed);
		apb(1'b1, A_SYS, wv);
		rdCmp(A_SYS, {5'h0, SRC_POR, wv[23:0]}, "system control rw");
		wv = $random(seed) | 32'h8000_0000;
		apb(1'b1, A_KEY, wv);
		rdCmp(A_KEY, wv, "key stored");
		compare(chipRst, 1'b0, "no reset on other value");
		rdCmp(12'h004, 32'h0, "unmapped read");
		compare(err, 1'b1, "unmapped error");
		compare(irq, 1'b0, "irq masked");
		apb(1'b1, A_MASK, 32'h1);
		@(posedge clk);
		compare(irq, 1'b1, "irq unmasked");
		apb(1'b1, A_STAT, 32'h7);
		expStat = 0;
		@(posedge clk);
		compare(irq, 1'b0, "irq cleared");
		rdCmp(A_STAT, expStat, "status cleared");
		$display("Test registers done");

		// Software reset, then again with a RAM check failure
		apb(1'b1, A_KEY, SW_RESET_KEY);
		compare(chipRst, 1'b1, "key enters reset");
		exitSeq(SWR - 3, SWR + 3, SRC_SW, 1'b0);
		compare(irq, 1'b1, "irq after exit");
		apb(1'b1, A_KEY, SW_RESET_KEY);
		compare(chipRst, 1'b1, "key enters reset again");
		exitSeq(SWR - 3, SWR + 3, SRC_SW, 1'b1);
		$display("Test software reset done");

		// Line reset: a low too short is ignored, a long one resets
		u_host_line_model.holdLow(RXLOW - 10);
		repeat (5) @(posedge clk);
		compare(chipRst, 1'b0, "short low ignored");
		u_host_line_model.holdLow(RXLOW + 10);
		compare(chipRst, 1'b1, "long low resets");
		exitSeq(RXR, RXR + 5, SRC_RX, 1'b0);
		$display("Test line reset done");

		// Supply loss while running
		supplyOk <= 1'b0;
		repeat (6) @(posedge clk);
		compare(chipRst, 1'b1, "supply loss resets");
		supplyOk <= 1'b1;
		exitSeq(POR, POR + 5, SRC_POR, 1'b0);
		$display("Test supply loss done");
		give_verdict;
	end
endmodule
